// [rtl/pxrd_cfg.svh]
`ifndef PXRD_CFG_SVH
`define PXRD_CFG_SVH
`define PXRD_OFF_CTRL     12'h000
`define PXRD_OFF_STATUS   12'h004
`define PXRD_OFF_RSVCNT   12'h008
`define PXRD_OFF_ILLCNT   12'h00c
`define PXRD_CTRL_EN      0
`define PXRD_CTRL_STRICT  1
`define PXRD_CTRL_RESET   2'h3
`define PXRD_DATA_BANK    4'h4
`define PXRD_ST_CODE_LSB  0
`define PXRD_ST_ILL_BIT   7
`define PXRD_ST_CLS_LSB   8
`endif

// [rtl/pxrd_decoder.sv]
// What this block does
// [RULE_01] Register field gives code's three low bits
// [RULE_02] Bank code above field forms 7-bit code
// [RULE_03] Same encoding for every register field role
// [RULE_04] Shared bank encoding for all bank fields
// [RULE_05] No bank given means data bank 0100
// [RULE_06] Omitted bank MSB forced to zero
// [RULE_07] Bank top bit 0 selects lower registers
// [RULE_08] Bank top bit 1 selects upper registers
// [RULE_09] Double parallel: data dest, no condition/protection
// [RULE_10] Enforce per-format operands, transfers, condition, protection
// [RULE_11] Slot decodes as load or store/address arithmetic
// [RULE_12] Relative addressing only in granting formats
// [RULE_13] Global low bank gives bits 5-3, bit6 zero
// [RULE_14] ALU destination bank gives bits 6-3
// [RULE_15] Flag codes that select reserved registers
`timescale 1ns/1ns
`default_nettype none
`include "pxrd_cfg.svh"
module pxrd_decoder (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                reqValid,
    input  wire pxrd_pkg::pxrd_req_t req,
    output var  pxrd_pkg::pxrd_resp_t resp,
    output logic                     respValid,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr
);
    logic [1:0]  rstPipe;
    logic        rstN;
    logic [1:0]  ctrl_reg;
    logic [15:0] rsvCnt_reg;
    logic [15:0] illCnt_reg;
    logic        apbAccess;
    logic        apbDone;
    logic        clrRsv;
    logic        clrIll;
    logic        take;
    logic [6:0]  code;
    pxrd_pkg::pxrd_caps_t caps;
    pxrd_pkg::pxrd_lvl_t  roleLvl;
    pxrd_pkg::pxrd_resp_t resp_next;
    logic        relOk;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    function automatic pxrd_pkg::pxrd_caps_t fmtCaps(
        input pxrd_pkg::pxrd_fmt_t f);
        pxrd_pkg::pxrd_caps_t c;
        c = '{pxrd_pkg::LVL_D, pxrd_pkg::LVL_D, pxrd_pkg::LVL_NONE,
              pxrd_pkg::LVL_NONE, pxrd_pkg::LVL_NONE, pxrd_pkg::LVL_NONE,
              1'b0, 1'b0, 1'b0, 1'b0};
        case (f)
            pxrd_pkg::FMT_DOUBLE: begin
                c.globalLvl = pxrd_pkg::LVL_LOWER; // RULE_09
                c.localLvl  = pxrd_pkg::LVL_D;
            end
            pxrd_pkg::FMT_MOVE_LOCAL: begin
                c.moveSrcLvl = pxrd_pkg::LVL_ANY;
                c.moveDstLvl = pxrd_pkg::LVL_ANY;
                c.localLvl   = pxrd_pkg::LVL_D;
                c.localRel   = 1'b1;
            end
            pxrd_pkg::FMT_FIELD_LOCAL: begin
                c.moveSrcLvl = pxrd_pkg::LVL_D;
                c.moveDstLvl = pxrd_pkg::LVL_ANY;
                c.localLvl   = pxrd_pkg::LVL_D;
            end
            pxrd_pkg::FMT_GLOBAL_LONG: begin
                c.globalLvl = pxrd_pkg::LVL_ANY;
                c.globalRel = 1'b1;
            end
            pxrd_pkg::FMT_LOCAL_LONG: begin
                c.localLvl = pxrd_pkg::LVL_ANY;
                c.localRel = 1'b1;
            end
            pxrd_pkg::FMT_NOND_LOCAL: begin
                c.dstLvl   = pxrd_pkg::LVL_ANY;
                c.srcLvl   = pxrd_pkg::LVL_ANY;
                c.localLvl = pxrd_pkg::LVL_D;
                c.localRel = 1'b1;
            end
            pxrd_pkg::FMT_COND_MOVE, pxrd_pkg::FMT_COND_FIELD: begin
                c.moveSrcLvl = (f == pxrd_pkg::FMT_COND_MOVE) ?
                               pxrd_pkg::LVL_ANY : pxrd_pkg::LVL_D;
                c.moveDstLvl = pxrd_pkg::LVL_ANY;
                c.hasCond    = 1'b1;
                c.hasProt    = 1'b1;
            end
            pxrd_pkg::FMT_COND_GLOBAL: begin
                c.globalLvl = pxrd_pkg::LVL_ANY;
                c.globalRel = 1'b1;
                c.hasCond   = 1'b1;
                c.hasProt   = 1'b1;
            end
            pxrd_pkg::FMT_COND_NOND: begin
                c.dstLvl  = pxrd_pkg::LVL_ANY;
                c.srcLvl  = pxrd_pkg::LVL_ANY;
                c.hasCond = 1'b1;
                c.hasProt = 1'b1;
            end
            pxrd_pkg::FMT_IMM32: begin
                c.dstLvl  = pxrd_pkg::LVL_ANY;
                c.srcLvl  = pxrd_pkg::LVL_LOWER;
                c.hasCond = 1'b1;
            end
            default: c.dstLvl = pxrd_pkg::LVL_NONE;
        endcase
        return c;
    endfunction : fmtCaps
    function automatic pxrd_pkg::pxrd_cls_t codeClass(input logic [6:0] k);
        pxrd_pkg::pxrd_cls_t r;
        r = pxrd_pkg::CLS_RESERVED;
        case (k[6:3])
            4'h0, 4'h1: if (k[2:0] != 3'h5) r = pxrd_pkg::CLS_ADDRESS;
            4'h2, 4'h3: if (k[2:0] < 3'h3) r = pxrd_pkg::CLS_INDEX;
            4'h4: r = pxrd_pkg::CLS_DATA;
            4'h5: begin
                if (k[2:0] == 3'h1) r = pxrd_pkg::CLS_STATUS;
                if (k[2:0] == 3'h2) r = pxrd_pkg::CLS_FLAGS;
            end
            4'h7: r = pxrd_pkg::CLS_CONTROL;
            4'hc: if (k[1:0] != 2'h3) r = k[2] ? pxrd_pkg::CLS_LOOP_RELOAD
                                               : pxrd_pkg::CLS_LOOP_COUNT;
            4'hd: if (k[1:0] != 2'h3) r = k[2] ? pxrd_pkg::CLS_RELOAD_START
                                               : pxrd_pkg::CLS_RELOAD_END;
            4'he: if (k[1:0] != 2'h3) r = k[2] ? pxrd_pkg::CLS_LOOP_END
                                               : pxrd_pkg::CLS_LOOP_START;
            4'hf: if (k[2]) r = pxrd_pkg::CLS_TAG;
            default: r = pxrd_pkg::CLS_RESERVED;
        endcase
        return r;
    endfunction : codeClass
    function automatic logic lvlOk(input pxrd_pkg::pxrd_lvl_t l,
                                   input logic [6:0] k);
        case (l)
            pxrd_pkg::LVL_D:     return k[6:3] == `PXRD_DATA_BANK;
            pxrd_pkg::LVL_LOWER: return !k[6];
            pxrd_pkg::LVL_ANY:   return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction : lvlOk
    // Code assembly, same for every field role and bank field
    always_comb begin
        case (req.bankMode) // RULE_03 RULE_04
            pxrd_pkg::BANK_LOW3: code = {1'b0, req.bank[2:0], req.field}; // RULE_06 RULE_13
            pxrd_pkg::BANK_FULL: code = {req.bank, req.field}; // RULE_02 RULE_14
            default:             code = {`PXRD_DATA_BANK, req.field}; // RULE_05 RULE_01
        endcase
    end

    always_comb begin
        caps = fmtCaps(req.fmt); // RULE_10
        case (req.role)
            pxrd_pkg::ROLE_ALU_DST:   roleLvl = caps.dstLvl; // RULE_09
            pxrd_pkg::ROLE_ALU_SRC:   roleLvl = caps.srcLvl;
            pxrd_pkg::ROLE_MOVE_SRC:  roleLvl = caps.moveSrcLvl;
            pxrd_pkg::ROLE_MOVE_DST:  roleLvl = caps.moveDstLvl;
            pxrd_pkg::ROLE_GLOBAL_SD: roleLvl = caps.globalLvl;
            pxrd_pkg::ROLE_LOCAL_SD:  roleLvl = caps.localLvl;
            pxrd_pkg::ROLE_ADDR:      roleLvl =
                (caps.globalLvl != pxrd_pkg::LVL_NONE ||
                 caps.localLvl != pxrd_pkg::LVL_NONE) ?
                pxrd_pkg::LVL_LOWER : pxrd_pkg::LVL_NONE;
            default:                  roleLvl = pxrd_pkg::LVL_NONE;
        endcase
        relOk = (req.role == pxrd_pkg::ROLE_GLOBAL_SD && caps.globalRel) ||
                (req.role == pxrd_pkg::ROLE_LOCAL_SD && caps.localRel); // RULE_12
        resp_next.code     = code;
        resp_next.upper    = code[6]; // RULE_07 RULE_08
        resp_next.regClass = codeClass(code);
        resp_next.reserved = resp_next.regClass == pxrd_pkg::CLS_RESERVED; // RULE_15
        resp_next.illegal  = !lvlOk(roleLvl, code) ||
                             (req.relReq && !relOk) ||
                             (req.condReq && !caps.hasCond) ||
                             (req.protReq && !caps.hasProt) ||
                             (ctrl_reg[`PXRD_CTRL_STRICT] &&
                              resp_next.reserved); // RULE_10 RULE_15
        if ((req.role == pxrd_pkg::ROLE_GLOBAL_SD ||
             req.role == pxrd_pkg::ROLE_LOCAL_SD) &&
            roleLvl != pxrd_pkg::LVL_NONE) begin
            resp_next.slot = req.loadSel ? pxrd_pkg::SLOT_LOAD
                                         : pxrd_pkg::SLOT_STORE_ARITH; // RULE_11
        end else begin
            resp_next.slot = pxrd_pkg::SLOT_NONE;
        end
    end

    assign take = reqValid && ctrl_reg[`PXRD_CTRL_EN];
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            resp      <= '0;
            respValid <= 1'b0;
        end else begin
            respValid <= take;
            if (take) begin
                resp <= resp_next;
            end
        end
    end
    // APB slave, answers on the second access cycle
    assign apbAccess = psel && penable;
    assign apbDone   = apbAccess && pready;
    assign clrRsv    = apbDone && pwrite && paddr == `PXRD_OFF_RSVCNT;
    assign clrIll    = apbDone && pwrite && paddr == `PXRD_OFF_ILLCNT;

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= apbAccess && !pready;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (apbAccess && !pready) begin
                case (paddr)
                    `PXRD_OFF_CTRL:   prdata <= {30'h0, ctrl_reg};
                    `PXRD_OFF_STATUS: begin
                        prdata[`PXRD_ST_CODE_LSB +: 7] <= resp.code;
                        prdata[`PXRD_ST_ILL_BIT]       <= resp.illegal;
                        prdata[`PXRD_ST_CLS_LSB +: 4]  <= resp.regClass;
                    end
                    `PXRD_OFF_RSVCNT: prdata <= {16'h0, rsvCnt_reg};
                    `PXRD_OFF_ILLCNT: prdata <= {16'h0, illCnt_reg};
                    default:          pslverr <= 1'b1;
                endcase
                if (pwrite && paddr == `PXRD_OFF_STATUS) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            ctrl_reg <= `PXRD_CTRL_RESET;
        end else if (apbDone && pwrite && paddr == `PXRD_OFF_CTRL) begin
            ctrl_reg <= pwdata[1:0];
        end
    end
    // A clear with a simultaneous event leaves the count at one
    always_ff @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            rsvCnt_reg <= 16'h0;
            illCnt_reg <= 16'h0;
        end else begin
            if (take && resp_next.reserved) begin
                rsvCnt_reg <= clrRsv ? 16'h1 : rsvCnt_reg + 16'h1;
            end else if (clrRsv) begin
                rsvCnt_reg <= 16'h0;
            end
            if (take && resp_next.illegal) begin
                illCnt_reg <= clrIll ? 16'h1 : illCnt_reg + 16'h1;
            end else if (clrIll) begin
                illCnt_reg <= 16'h0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstN);
    property p_low_bits;
        take |=> resp.code[2:0] == $past(req.field);
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low bits"); // RULE_01
    property p_default_bank;
        take && req.bankMode == pxrd_pkg::BANK_NONE |=>
            resp.code[6:3] == 4'h4;
    endproperty
    a_default_bank: assert property (p_default_bank) else $error("bank"); // RULE_05
    property p_low3_bank;
        take && req.bankMode == pxrd_pkg::BANK_LOW3 |=>
            !resp.code[6] && resp.code[5:3] == $past(req.bank[2:0]);
    endproperty
    a_low3_bank: assert property (p_low3_bank) else $error("low3"); // RULE_06
    property p_full_bank;
        take && req.bankMode == pxrd_pkg::BANK_FULL |=>
            resp.code[6:3] == $past(req.bank);
    endproperty
    a_full_bank: assert property (p_full_bank) else $error("full"); // RULE_14
    property p_upper;
        respValid |-> resp.upper == resp.code[6] &&
            (resp.regClass == pxrd_pkg::CLS_RESERVED ||
             resp.upper == (resp.regClass >= pxrd_pkg::CLS_LOOP_COUNT));
    endproperty
    a_upper: assert property (p_upper) else $error("upper"); // RULE_08
    property p_double_cond;
        take && req.fmt == pxrd_pkg::FMT_DOUBLE &&
            (req.condReq || req.protReq) |=> respValid && resp.illegal;
    endproperty
    a_double_cond: assert property (p_double_cond) else $error("dbl"); // RULE_09
    property p_rel;
        take && req.relReq && req.fmt == pxrd_pkg::FMT_FIELD_LOCAL |=>
            resp.illegal;
    endproperty
    a_rel: assert property (p_rel) else $error("rel"); // RULE_12
    property p_reserved;
        respValid && resp.code[6:4] == 3'h4 |-> resp.reserved;
    endproperty
    a_reserved: assert property (p_reserved) else $error("rsv"); // RULE_15
    property p_slot;
        take && req.role == pxrd_pkg::ROLE_GLOBAL_SD &&
            req.fmt == pxrd_pkg::FMT_GLOBAL_LONG |=>
            resp.slot == ($past(req.loadSel) ? pxrd_pkg::SLOT_LOAD
                                             : pxrd_pkg::SLOT_STORE_ARITH);
    endproperty
    a_slot: assert property (p_slot) else $error("slot"); // RULE_11
    property p_alu_dst;
        take && req.role == pxrd_pkg::ROLE_ALU_DST &&
            req.fmt == pxrd_pkg::FMT_COND_MOVE &&
            req.bankMode == pxrd_pkg::BANK_FULL && req.bank != 4'h4 |=>
            resp.illegal && (illCnt_reg == 16'h1 ||
                             illCnt_reg == $past(illCnt_reg) + 16'h1);
    endproperty
    a_alu_dst: assert property (p_alu_dst) else $error("dst"); // RULE_10
    property p_apb_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb");
    c_tag: cover property (respValid && resp.regClass == pxrd_pkg::CLS_TAG);
    c_illegal: cover property (respValid && resp.illegal);
    c_load: cover property (respValid && resp.slot == pxrd_pkg::SLOT_LOAD);
    c_apb_err: cover property (pready && pslverr);
endmodule : pxrd_decoder
`default_nettype wire

// [rtl/pxrd_pkg.sv]
package pxrd_pkg;
    typedef enum logic [3:0] {
        FMT_DOUBLE, FMT_MOVE_LOCAL, FMT_FIELD_LOCAL, FMT_GLOBAL_LONG,
        FMT_LOCAL_LONG, FMT_NOND_LOCAL, FMT_COND_MOVE, FMT_COND_FIELD,
        FMT_COND_GLOBAL, FMT_COND_NOND, FMT_IMM32
    } pxrd_fmt_t;
    typedef enum logic [1:0] {BANK_NONE, BANK_LOW3, BANK_FULL} pxrd_bmode_t;
    typedef enum logic [2:0] {
        ROLE_ALU_DST, ROLE_ALU_SRC, ROLE_MOVE_SRC, ROLE_MOVE_DST,
        ROLE_GLOBAL_SD, ROLE_LOCAL_SD, ROLE_ADDR
    } pxrd_role_t;
    typedef enum logic [1:0] {LVL_NONE, LVL_D, LVL_LOWER, LVL_ANY} pxrd_lvl_t;
    typedef enum logic [1:0] {SLOT_NONE, SLOT_LOAD, SLOT_STORE_ARITH}
        pxrd_slot_t;
    typedef enum logic [3:0] {
        CLS_ADDRESS, CLS_INDEX, CLS_DATA, CLS_STATUS, CLS_FLAGS,
        CLS_CONTROL, CLS_LOOP_COUNT, CLS_LOOP_RELOAD, CLS_RELOAD_END,
        CLS_RELOAD_START, CLS_LOOP_START, CLS_LOOP_END, CLS_TAG,
        CLS_RESERVED
    } pxrd_cls_t;
    typedef struct packed {
        pxrd_fmt_t   fmt;
        pxrd_role_t  role;
        pxrd_bmode_t bankMode;
        logic [3:0]  bank;
        logic [2:0]  field;
        logic        loadSel;
        logic        relReq;
        logic        condReq;
        logic        protReq;
    } pxrd_req_t;
    typedef struct packed {
        pxrd_lvl_t dstLvl;
        pxrd_lvl_t srcLvl;
        pxrd_lvl_t moveSrcLvl;
        pxrd_lvl_t moveDstLvl;
        pxrd_lvl_t globalLvl;
        pxrd_lvl_t localLvl;
        logic      hasCond;
        logic      hasProt;
        logic      globalRel;
        logic      localRel;
    } pxrd_caps_t;
    typedef struct packed {
        logic [6:0] code;
        logic       upper;
        logic       reserved;
        pxrd_cls_t  regClass;
        logic       illegal;
        pxrd_slot_t slot;
    } pxrd_resp_t;
endpackage : pxrd_pkg

// [tb/pxrd_fetch_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pxrd_fetch_model (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic                issue,
    input  wire pxrd_pkg::pxrd_req_t issueReq,
    output var  logic                reqValid,
    output var  pxrd_pkg::pxrd_req_t req
);
    // Fields churn between requests so stale values never look valid
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reqValid <= 1'b0;
            req      <= '0;
        end else if (issue) begin
            reqValid <= 1'b1;
            req      <= issueReq;
        end else begin
            reqValid <= 1'b0;
            req      <= pxrd_pkg::pxrd_req_t'(~req);
        end
    end
endmodule : pxrd_fetch_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {
        pxrd_pkg::pxrd_bmode_t bm;
        logic [3:0]            bank;
        logic [2:0]            field;
        logic [6:0]            code;
        pxrd_pkg::pxrd_cls_t   cls;
    } pxrd_row_t;
    logic                 clock;
    logic                 reset_n;
    logic                 issue;
    pxrd_pkg::pxrd_req_t  issueReq;
    logic                 reqValid;
    pxrd_pkg::pxrd_req_t  req;
    pxrd_pkg::pxrd_resp_t resp;
    pxrd_pkg::pxrd_resp_t saved;
    logic                 respValid;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          rd;
    logic [31:0]          stExp;
    logic                 se;
    int                   err_count = 0;
    int                   n_tests = 0;
    int                   rsv;
    pxrd_row_t            rows [17] = '{
        '{pxrd_pkg::BANK_NONE, 4'hf, 3'h5, 7'h25, pxrd_pkg::CLS_DATA},
        '{pxrd_pkg::BANK_LOW3, 4'hd, 3'h2, 7'h2a, pxrd_pkg::CLS_FLAGS},
        '{pxrd_pkg::BANK_LOW3, 4'h9, 3'h1, 7'h09, pxrd_pkg::CLS_ADDRESS},
        '{pxrd_pkg::BANK_FULL, 4'h5, 3'h0, 7'h28, pxrd_pkg::CLS_RESERVED},
        '{pxrd_pkg::BANK_FULL, 4'h5, 3'h1, 7'h29, pxrd_pkg::CLS_STATUS},
        '{pxrd_pkg::BANK_FULL, 4'h7, 3'h1, 7'h39, pxrd_pkg::CLS_CONTROL},
        '{pxrd_pkg::BANK_FULL, 4'h2, 3'h2, 7'h12, pxrd_pkg::CLS_INDEX},
        '{pxrd_pkg::BANK_FULL, 4'h0, 3'h5, 7'h05, pxrd_pkg::CLS_RESERVED},
        '{pxrd_pkg::BANK_FULL, 4'h8, 3'h3, 7'h43, pxrd_pkg::CLS_RESERVED},
        '{pxrd_pkg::BANK_FULL, 4'hc, 3'h0, 7'h60, pxrd_pkg::CLS_LOOP_COUNT},
        '{pxrd_pkg::BANK_FULL, 4'hc, 3'h5, 7'h65, pxrd_pkg::CLS_LOOP_RELOAD},
        '{pxrd_pkg::BANK_FULL, 4'hd, 3'h0, 7'h68, pxrd_pkg::CLS_RELOAD_END},
        '{pxrd_pkg::BANK_FULL, 4'hd, 3'h6, 7'h6e, pxrd_pkg::CLS_RELOAD_START},
        '{pxrd_pkg::BANK_FULL, 4'he, 3'h0, 7'h70, pxrd_pkg::CLS_LOOP_START},
        '{pxrd_pkg::BANK_FULL, 4'he, 3'h4, 7'h74, pxrd_pkg::CLS_LOOP_END},
        '{pxrd_pkg::BANK_FULL, 4'hf, 3'h0, 7'h78, pxrd_pkg::CLS_RESERVED},
        '{pxrd_pkg::BANK_FULL, 4'hf, 3'h7, 7'h7f, pxrd_pkg::CLS_TAG}};

    pxrd_fetch_model fetch (.clock(clock), .reset_n(reset_n), .issue(issue),
        .issueReq(issueReq), .reqValid(reqValid), .req(req));
    pxrd_decoder uut (.clock(clock), .reset_n(reset_n), .reqValid(reqValid),
        .req(req), .resp(resp), .respValid(respValid), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic decode(input pxrd_pkg::pxrd_req_t r, input logic v);
        @(posedge clock);
        issue    <= 1'b1;
        issueReq <= r;
        @(posedge clock);
        issue <= 1'b0;
        @(posedge clock);
        #1;
        chk("respValid", 32'(v), 32'(respValid));
        @(posedge clock);
        #1;
        chk("respValid low", 32'h0, 32'(respValid));
    endtask : decode

    task automatic leg(input pxrd_pkg::pxrd_fmt_t f,
                       input pxrd_pkg::pxrd_role_t ro,
                       input pxrd_pkg::pxrd_bmode_t bm, input logic [3:0] b,
                       input logic [2:0] fl, input logic [3:0] x,
                       input logic ill, input pxrd_pkg::pxrd_slot_t sl);
        pxrd_pkg::pxrd_req_t r;
        r = '{f, ro, bm, b, fl, x[3], x[2], x[1], x[0]};
        decode(r, 1'b1);
        chk("illegal", 32'(ill), 32'(resp.illegal));
        chk("slot", 32'(sl), 32'(resp.slot));
    endtask : leg

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #100000;
        err_count++;
        results();
    end

    initial begin
        reset_n = 1'b0;
        issue = 1'b0;
        issueReq = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge clock);
        #1;
        chk("reset resp", 32'h0, 32'(resp));
        chk("reset respValid", 32'h0, 32'(respValid));
        chk("reset pready", 32'h0, 32'(pready));
        @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h3, rd);
        chk("ctrl err", 32'h0, 32'(se));
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        rsv = 0;
        foreach (rows[i]) begin
            leg(pxrd_pkg::FMT_MOVE_LOCAL, pxrd_pkg::ROLE_MOVE_SRC, rows[i].bm,
                rows[i].bank, rows[i].field, 4'h0,
                rows[i].cls == pxrd_pkg::CLS_RESERVED, pxrd_pkg::SLOT_NONE);
            chk("code", 32'(rows[i].code), 32'(resp.code));
            chk("upper", 32'(rows[i].code[6]), 32'(resp.upper));
            chk("class", 32'(rows[i].cls), 32'(resp.regClass));
            chk("reserved", 32'(rows[i].cls == pxrd_pkg::CLS_RESERVED),
                32'(resp.reserved));
            stExp = {20'h0, rows[i].cls, rows[i].cls == pxrd_pkg::CLS_RESERVED,
                     rows[i].code};
            rsv += int'(rows[i].cls == pxrd_pkg::CLS_RESERVED);
        end
        apb(1'b0, 12'h004, 32'h0);
        chk("status", stExp, rd);
        apb(1'b0, 12'h008, 32'h0);
        chk("reserved count", 32'(rsv), rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("illegal count", 32'(rsv), rd);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("cleared count", 32'h0, rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("illegal kept", 32'(rsv), rd);
        apb(1'b1, 12'h004, 32'h5);
        chk("status write err", 32'h1, 32'(se));
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped err", 32'h1, 32'(se));
        apb(1'b1, 12'h000, 32'h1);
        leg(pxrd_pkg::FMT_MOVE_LOCAL, pxrd_pkg::ROLE_MOVE_DST,
            pxrd_pkg::BANK_FULL, 4'h5, 3'h0, 4'h0, 1'b0,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_ALU_DST, pxrd_pkg::BANK_NONE,
            4'h0, 3'h3, 4'h0, 1'b0, pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_ALU_DST, pxrd_pkg::BANK_FULL,
            4'h0, 3'h3, 4'h0, 1'b1, pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_ALU_DST, pxrd_pkg::BANK_NONE,
            4'h0, 3'h3, 4'h2, 1'b1, pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_ALU_DST, pxrd_pkg::BANK_NONE,
            4'h0, 3'h3, 4'h1, 1'b1, pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_COND_GLOBAL, pxrd_pkg::ROLE_ALU_DST,
            pxrd_pkg::BANK_NONE, 4'h0, 3'h1, 4'h3, 1'b0,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_GLOBAL_LONG, pxrd_pkg::ROLE_GLOBAL_SD,
            pxrd_pkg::BANK_FULL, 4'he, 3'h4, 4'hc, 1'b0,
            pxrd_pkg::SLOT_LOAD);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_GLOBAL_SD,
            pxrd_pkg::BANK_LOW3, 4'h1, 3'h1, 4'hc, 1'b1,
            pxrd_pkg::SLOT_LOAD);
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_GLOBAL_SD,
            pxrd_pkg::BANK_LOW3, 4'h9, 3'h1, 4'h0, 1'b0,
            pxrd_pkg::SLOT_STORE_ARITH);
        chk("low3 code", 32'h09, 32'(resp.code));
        leg(pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_GLOBAL_SD,
            pxrd_pkg::BANK_FULL, 4'hc, 3'h0, 4'h0, 1'b1,
            pxrd_pkg::SLOT_STORE_ARITH);
        leg(pxrd_pkg::FMT_COND_MOVE, pxrd_pkg::ROLE_GLOBAL_SD,
            pxrd_pkg::BANK_NONE, 4'h0, 3'h0, 4'h8, 1'b1,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_LOCAL_LONG, pxrd_pkg::ROLE_LOCAL_SD,
            pxrd_pkg::BANK_FULL, 4'hc, 3'h1, 4'h4, 1'b0,
            pxrd_pkg::SLOT_STORE_ARITH);
        leg(pxrd_pkg::FMT_FIELD_LOCAL, pxrd_pkg::ROLE_LOCAL_SD,
            pxrd_pkg::BANK_NONE, 4'h0, 3'h2, 4'hc, 1'b1,
            pxrd_pkg::SLOT_LOAD);
        leg(pxrd_pkg::FMT_NOND_LOCAL, pxrd_pkg::ROLE_ALU_DST,
            pxrd_pkg::BANK_FULL, 4'he, 3'h4, 4'h0, 1'b0,
            pxrd_pkg::SLOT_NONE);
        chk("alu dest code", 32'h74, 32'(resp.code));
        leg(pxrd_pkg::FMT_GLOBAL_LONG, pxrd_pkg::ROLE_ALU_SRC,
            pxrd_pkg::BANK_FULL, 4'h0, 3'h1, 4'h0, 1'b1,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_IMM32, pxrd_pkg::ROLE_ALU_SRC, pxrd_pkg::BANK_FULL,
            4'hc, 3'h0, 4'h0, 1'b1, pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_FIELD_LOCAL, pxrd_pkg::ROLE_MOVE_SRC,
            pxrd_pkg::BANK_FULL, 4'h0, 3'h1, 4'h0, 1'b1,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_COND_MOVE, pxrd_pkg::ROLE_ALU_DST,
            pxrd_pkg::BANK_FULL, 4'h0, 3'h1, 4'h0, 1'b1,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_GLOBAL_LONG, pxrd_pkg::ROLE_ADDR,
            pxrd_pkg::BANK_FULL, 4'h0, 3'h2, 4'h0, 1'b0,
            pxrd_pkg::SLOT_NONE);
        leg(pxrd_pkg::FMT_COND_MOVE, pxrd_pkg::ROLE_ADDR,
            pxrd_pkg::BANK_FULL, 4'h0, 3'h2, 4'h0, 1'b1,
            pxrd_pkg::SLOT_NONE);
        apb(1'b1, 12'h000, 32'h0);
        saved = resp;
        decode('{pxrd_pkg::FMT_DOUBLE, pxrd_pkg::ROLE_ALU_DST,
                 pxrd_pkg::BANK_NONE, 4'h0, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0},
               1'b0);
        chk("resp kept", 32'(saved), 32'(resp));
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        chk("mid reset resp", 32'h0, 32'(resp));
        repeat (3) @(posedge clock);
        apb(1'b0, 12'h000, 32'h0);
        chk("mid reset ctrl", 32'h3, rd);
        apb(1'b0, 12'h00c, 32'h0);
        chk("mid reset count", 32'h0, rd);
        results();
    end
endmodule : tb_top
`default_nettype wire
